// ===== design/bap_consts.svh
`ifndef BAP_CONSTS_SVH
`define BAP_CONSTS_SVH

`define BAP_CLK_HZ 28'h5F5_E100
`define BAP_REF_HZ 28'h1E8_4800
`define BAP_DIV_DEN 28'h000_0FA0
`define BAP_ACC_W 28
`define BAP_DIV_MIN 9'h008
`define BAP_DIV_MAX 9'h100
`define BAP_DATA_W 16
`define BAP_SLOT_MAX 5'h10
`define BAP_SLOTS_MAX 6'h20
`define BAP_FRAME_MAX 9'h100
`define BAP_FIFO_DEPTH 16

`endif

// ===== design/bap_pkg.sv
`include "bap_consts.svh"
`default_nettype none
package bap_pkg;

  // Static configuration of the port, held stable while the port is enabled.
  typedef struct packed {
    logic master;
    logic [8:0] div_n;
    logic [5:0] slots;
    logic [4:0] slot_bits;
    logic [8:0] frame_bits;
  } bap_cfg_t;

  // One audio word with the slot it belongs to, data right aligned.
  typedef struct packed {
    logic [4:0] slot;
    logic [`BAP_DATA_W-1:0] data;
  } bap_word_t;

  // Frame sequencer states, Gray along idle, data, pad.
  typedef enum logic [1:0] {
    BAP_IDLE = 2'b00,
    BAP_DATA = 2'b01,
    BAP_PAD = 2'b11
  } bap_phase_t;

  // Whole state of the port.
  typedef struct packed {
    logic clk_s1;
    logic clk_s2;
    logic clk_s3;
    logic sy_s1;
    logic sy_s2;
    logic din_s1;
    logic din_s2;
    logic drive;
    logic [`BAP_ACC_W-1:0] acc;
    logic bclk;
    logic fsync;
    logic [8:0] mcnt;
    logic sync_prev;
    bap_phase_t phase;
    logic [4:0] bis;
    logic [4:0] sidx;
    logic [`BAP_DATA_W-1:0] tx_sh;
    logic dout;
    logic [`BAP_DATA_W-1:0] rx_sh;
    logic rx_push;
    bap_word_t rx_word;
    logic overrun;
    logic underrun;
  } bap_state_t;

endpackage : bap_pkg
`default_nettype wire

// ===== design/bap_fifo.sv
`default_nettype none
module bap_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  // Storage plus a registered output stage, so read data leave a flop.
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ov;
    logic [WIDTH-1:0] od;
  } bap_fifo_state_t;

  bap_fifo_state_t q;
  bap_fifo_state_t d;
  logic push;
  logic pop;

  // Depth must be a power of two so the pointers wrap by themselves.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
  begin : g_bad
    $error("bap_fifo: DEPTH must be a power of two of at least 2");
  end

  assign in_ready = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid = q.ov;
  assign out_data = q.od;

  // Write side and the refill of the output stage from storage.
  always_comb
  begin
    d = q;
    push = in_valid & in_ready;
    pop = 1'b0;
    if (push)
    begin
      d.mem[q.wp] = in_data;
      d.wp = q.wp + 1'b1;
    end
    if ((!q.ov || out_ready) && q.cnt != '0)
    begin
      pop = 1'b1;
      d.od = q.mem[q.rp];
      d.rp = q.rp + 1'b1;
      d.ov = 1'b1;
    end
    else if (out_ready)
    begin
      d.ov = 1'b0;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // The clock enable freezes storage and pointers alike.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '0;
    end
    else if (ce)
    begin
      q <= d;
    end
  end
endmodule : bap_fifo
`default_nettype wire

// ===== design/bap_port.sv
`include "bap_consts.svh"
`default_nettype none
module bap_port #(
  parameter int FIFO_DEPTH = `BAP_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic enable,
  input wire bap_pkg::bap_cfg_t cfg,
  input wire logic bclk_i,
  output logic bclk_o,
  output logic bclk_oe,
  input wire logic fsync_i,
  output logic fsync_o,
  output logic fsync_oe,
  input wire logic din_i,
  output logic dout_o,
  input wire logic tx_valid,
  input wire logic [`BAP_DATA_W-1:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output bap_pkg::bap_word_t rx_data,
  input wire logic rx_ready,
  output logic rx_overrun,
  output logic tx_underrun
);
  localparam int WORD_W = $bits(bap_pkg::bap_word_t);

  // Accumulator step per unit of N: two clock edges per bit clock period.
  localparam logic [`BAP_ACC_W-1:0] STEP_PER_N =
    `BAP_ACC_W'((`BAP_REF_HZ + `BAP_REF_HZ) / `BAP_DIV_DEN);

  // Largest accumulator step that the divider setting can ask for.
  localparam logic [`BAP_ACC_W-1:0] STEP_MAX =
    `BAP_ACC_W'(STEP_PER_N * `BAP_DIV_MAX);

  // How a frame runs through this port, one bit clock at a time.
  // The bit clock is either made here from the accumulator or taken from
  // the pin, and both paths end in one pair of strobes, rise and fall, so
  // the sequencer below never knows which side is the bus master.
  // On a fall the sync level is compared with the level of the previous
  // fall; a low to high step marks the start of a frame and resets the
  // slot and bit counters wherever they stood.
  // The first data bit leaves on the rise after that fall and is sampled
  // back on the fall that follows, so every slot spans exactly slot_bits
  // bit clocks with the most significant bit first.
  // Once the last slot is done the data line stays low until the next
  // sync; a frame longer than its slots is simply padded.
  // Received words leave through the buffer; when it is full the word is
  // dropped and a one-cycle overrun pulse tells the user side.
  // The trade-off of the fractional divider is a one-cycle jitter on each
  // edge, which keeps the mean rate exact for every N without a PLL.

  bap_pkg::bap_state_t q;
  bap_pkg::bap_state_t d;
  logic rise;
  logic fall;
  logic sync_now;
  logic fifo_in_ready;
  logic [`BAP_ACC_W-1:0] step;
  logic [`BAP_ACC_W-1:0] sum;
  logic [`BAP_DATA_W-1:0] sh;
  logic [`BAP_DATA_W-1:0] rxv;

  // The receive buffer needs room for at least two words to be useful.
  if (FIFO_DEPTH < 2)
  begin : g_bad
    $error("bap_port: FIFO_DEPTH must be at least 2");
  end

  // One step must stay below a whole system clock, or a toggle is lost.
  if (STEP_MAX >= `BAP_CLK_HZ)
  begin : g_bad_step
    $error("bap_port: bit clock step too large for the system clock");
  end

  // The accumulator must hold the clock rate plus the largest step.
  if (int'(`BAP_CLK_HZ) + int'(STEP_MAX) >= (1 << `BAP_ACC_W))
  begin : g_bad_acc
    $error("bap_port: accumulator too narrow for the divider");
  end

  // The shift registers must hold the longest slot.
  if (`BAP_DATA_W < int'(`BAP_SLOT_MAX))
  begin : g_bad_data
    $error("bap_port: data width below the longest slot");
  end

  // The slot index must count every slot of the widest frame.
  if ((1 << $bits(q.sidx)) < int'(`BAP_SLOTS_MAX))
  begin : g_bad_slots
    $error("bap_port: slot index too narrow");
  end

  // The frame counter must reach the longest frame.
  if ((1 << $bits(q.mcnt)) <= int'(`BAP_FRAME_MAX))
  begin : g_bad_frame
    $error("bap_port: frame counter too narrow");
  end

  // Pins facing the bus come straight from flops.
  assign bclk_o = q.bclk;
  assign fsync_o = q.fsync;
  assign bclk_oe = q.drive;
  assign fsync_oe = q.drive;
  assign dout_o = q.dout;
  assign rx_overrun = q.overrun;
  assign tx_underrun = q.underrun;

  // Next state of the whole port.
  always_comb
  begin
    d = q;
    d.rx_push = 1'b0;
    d.overrun = 1'b0;
    d.underrun = 1'b0;
    tx_ready = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    sh = q.tx_sh;
    rxv = {q.rx_sh[`BAP_DATA_W-2:0], q.din_s2};
    step = STEP_PER_N * `BAP_ACC_W'(cfg.div_n);
    sum = q.acc + step;

    // Pins from the other side pass two flops before any use.
    d.clk_s1 = bclk_i;
    d.clk_s2 = q.clk_s1;
    d.clk_s3 = q.clk_s2;
    d.sy_s1 = fsync_i;
    d.sy_s2 = q.sy_s1;
    d.din_s1 = din_i;
    d.din_s2 = q.din_s1;

    // A push the buffer could not take is lost and reported once.
    d.overrun = q.rx_push & ~fifo_in_ready;
    d.drive = enable & cfg.master;

    if (!enable)
    begin
      // Parked: no clock, no sync, quiet data line.
      d.acc = '0;
      d.bclk = 1'b0;
      d.fsync = 1'b0;
      d.mcnt = '0;
      d.sync_prev = 1'b0;
      d.phase = bap_pkg::BAP_IDLE;
      d.dout = 1'b0;
    end
    else
    begin
      if (cfg.master)
      begin
        // Fractional divider; each wrap toggles the bit clock, so the edge
        // spacing jitters by one system clock but the mean rate is exact.
        if (sum >= `BAP_CLK_HZ)
        begin
          d.acc = sum - `BAP_CLK_HZ;
          d.bclk = ~q.bclk;
          rise = ~q.bclk;
          fall = q.bclk;
        end
        else
        begin
          d.acc = sum;
        end
      end
      else
      begin
        // Edges found on synchronised levels; a slow outside clock gives
        // many system clocks per half period, so no edge is missed.
        rise = q.clk_s2 & ~q.clk_s3;
        fall = ~q.clk_s2 & q.clk_s3;
      end

      // Long sync: high for the first slot of each master frame.
      if (rise && cfg.master)
      begin
        d.fsync = (q.mcnt < {4'h0, cfg.slot_bits}) &&
                  (q.mcnt < cfg.frame_bits - 9'h001);
        if (q.mcnt >= cfg.frame_bits - 9'h001)
        begin
          d.mcnt = '0;
        end
        else
        begin
          d.mcnt = q.mcnt + 9'h001;
        end
      end

      // Transmit: a new bit leaves on each rising edge inside the slots.
      if (rise)
      begin
        if (q.phase == bap_pkg::BAP_DATA)
        begin
          if (q.bis == '0)
          begin
            if (tx_valid)
            begin
              tx_ready = 1'b1;
              sh = tx_data << (`BAP_SLOT_MAX - cfg.slot_bits);
            end
            else
            begin
              d.underrun = 1'b1;
              sh = '0;
            end
          end
          d.dout = sh[`BAP_DATA_W-1];
          d.tx_sh = sh << 1;
        end
        else
        begin
          d.dout = 1'b0;
        end
      end

      // Receive and sync detection on the falling edge.
      if (fall)
      begin
        d.sync_prev = sync_now;
        if (sync_now && !q.sync_prev)
        begin
          // A fresh sync restarts the frame wherever it stood.
          d.phase = bap_pkg::BAP_DATA;
          d.bis = '0;
          d.sidx = '0;
          d.rx_sh = '0;
        end
        else
        begin
          unique case (q.phase)
            bap_pkg::BAP_IDLE,
            bap_pkg::BAP_PAD:
            begin
              d.phase = q.phase;
            end
            bap_pkg::BAP_DATA:
            begin
              d.rx_sh = rxv;
              if (q.bis == cfg.slot_bits - 5'h01)
              begin
                d.rx_push = 1'b1;
                d.rx_word.slot = q.sidx;
                d.rx_word.data = rxv;
                d.rx_sh = '0;
                d.bis = '0;
                if (q.sidx == 5'(cfg.slots - 6'h01))
                begin
                  d.phase = bap_pkg::BAP_PAD;
                end
                else
                begin
                  d.sidx = q.sidx + 5'h01;
                end
              end
              else
              begin
                d.bis = q.bis + 5'h01;
              end
            end
            default:
            begin
              d.phase = bap_pkg::BAP_IDLE;
            end
          endcase
        end
      end
    end
  end

  // The sync seen on a falling edge is our own as master, the pin as slave.
  assign sync_now = cfg.master ? q.fsync : q.sy_s2;

  // One register for all state; the clock enable freezes everything.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '0;
    end
    else if (ce)
    begin
      q <= d;
    end
  end

  // Received words wait here until the user side takes them.
  bap_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .in_valid(q.rx_push),
    .in_data(q.rx_word),
    .in_ready(fifo_in_ready),
    .out_valid(rx_valid),
    .out_data(rx_data),
    .out_ready(rx_ready)
  );
endmodule : bap_port
`default_nettype wire

// ===== design/bap_unused_guard_none.sv
`default_nettype none
`default_nettype wire

// ===== test/bap_codec_model.sv
`default_nettype none
module bap_codec_model #(
  parameter int FRAME_BITS = 20
) (
  input wire logic master,
  input wire logic run,
  input wire logic bclk_o,
  input wire logic dout_o,
  output logic bclk_i,
  output logic fsync_i,
  output logic din_i
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic sclk;

  // The bit clock in use, whoever makes it.
  assign sclk = master ? bclk_o : bclk_i;

  // Bus master at 2 MHz with a one-bit sync; the clock runs frame after
  // frame with no gap and an idle data line wanders, so stale bits are never trusted.
  initial
  begin
    bclk_i = 1'b0;
    fsync_i = 1'b0;
    din_i = 1'b0;
    forever
      if (run && !master)
        for (int b = 0; b < FRAME_BITS; b++)
        begin
          fsync_i = (b == 0);
          bclk_i = 1'b1;
          #250;
          bclk_i = 1'b0;
          #250;
        end
      else
      begin
        #100;
        din_i = run ? din_i : ~din_i;
      end
  end

  // Echo the port's output a little after each rise, held across the fall.
  always @(posedge sclk)
  begin
    #60;
    din_i = dout_o;
  end

endmodule : bap_codec_model
`default_nettype wire

// ===== test/bap_port_checker.sv
`include "bap_consts.svh"
`default_nettype none
module bap_port_checker #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire bap_pkg::bap_cfg_t cfg,
  input wire logic bclk_o,
  input wire logic bclk_oe,
  input wire logic fsync_o,
  input wire logic fsync_oe,
  input wire logic dout_o,
  input wire logic tx_valid,
  input wire logic [`BAP_DATA_W-1:0] tx_data,
  input wire logic tx_ready,
  input wire logic tx_underrun,
  input wire logic rx_valid,
  input wire bap_pkg::bap_word_t rx_data,
  input wire logic rx_ready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  logic bclk_q;
  logic seen_q;
  logic [12:0] gap_q;
  logic [12:0] half_lo;

  // Shortest half period in clk cycles, 1e8 over 16000 N.
  assign half_lo = 13'h186A / {4'h0, cfg.div_n};

  // Cycles since the driven clock moved; the first toggle only arms it.
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      bclk_q <= 1'b0;
      seen_q <= 1'b0;
      gap_q <= 13'h0000;
    end
    else
    begin
      bclk_q <= bclk_o;
      seen_q <= bclk_oe && (seen_q || bclk_o != bclk_q);
      gap_q <= (bclk_o != bclk_q || !bclk_oe) ? 13'h0000 : gap_q + 13'h0001;
    end

  // Steady master drive, and a word handed over.
  sequence s_driving;
    enable && bclk_oe && $past(bclk_oe);
  endsequence
  sequence s_took;
    tx_valid && tx_ready;
  endsequence

  chk_half_period:
    assert property (enable && seen_q && bclk_oe && bclk_o != bclk_q
      |-> gap_q + 13'h0001 >= half_lo && gap_q <= half_lo)
    else $error("bit clock half period off");
  chk_master_drives:
    assert property ((cfg.master && enable) [*2] |-> bclk_oe && fsync_oe)
    else $error("master not driving");
  chk_slave_listens:
    assert property (!cfg.master |=> !bclk_oe && !fsync_oe)
    else $error("slave driving");
  chk_dout_launch:
    assert property (s_driving ##0 dout_o != $past(dout_o) |-> $rose(bclk_o))
    else $error("data moved off a rise");
  chk_sync_launch:
    assert property (s_driving ##0 $changed(fsync_o) |-> $rose(bclk_o))
    else $error("sync moved off a rise");
  chk_take_msb:
    assert property (tx_ready |-> s_took ##1
      dout_o == 1'($past(tx_data) >> (cfg.slot_bits - 5'h01)))
    else $error("slot not sent msb first");
  chk_underrun_zero:
    assert property (tx_underrun |-> !$past(tx_valid) && !dout_o)
    else $error("underrun wrong");
  chk_rx_hold:
    assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("rx word not held");

endmodule : bap_port_checker

bind bap_port bap_port_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk (.clk,
  .reset_n, .enable, .cfg, .bclk_o, .bclk_oe, .fsync_o, .fsync_oe, .dout_o,
  .tx_valid, .tx_data, .tx_ready, .tx_underrun, .rx_valid, .rx_data,
  .rx_ready);
`default_nettype wire

// ===== test/bap_port_test.sv
`include "bap_consts.svh"
`default_nettype none
module bap_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, enable, run, bclk_i, bclk_o, bclk_oe, fsync_i;
  logic fsync_o, fsync_oe, din_i, dout_o, tx_valid, tx_ready, rx_valid;
  logic rx_ready, rx_overrun, tx_underrun;
  logic [15:0] tx_data;
  bap_pkg::bap_cfg_t cfg;
  bap_pkg::bap_word_t rx_data;
  logic [15:0] sent[$];
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;

  bap_port #(.FIFO_DEPTH(16)) DUT (.clk, .reset_n, .ce(1'b1), .enable, .cfg,
    .bclk_i, .bclk_o, .bclk_oe, .fsync_i, .fsync_o, .fsync_oe, .din_i,
    .dout_o, .tx_valid, .tx_data, .tx_ready, .rx_valid, .rx_data,
    .rx_ready, .rx_overrun, .tx_underrun);
  bap_codec_model codec (.master(cfg.master), .run, .bclk_o, .dout_o,
    .bclk_i, .fsync_i, .din_i);

  // Free-running 100 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Watchdog, and a fresh word offered each time the port takes one.
  always @(posedge clk)
  begin
    cycles++;
    if (tx_ready === 1'b1)
    begin
      sent.push_back(tx_data);
      tx_data <= tx_data + 16'h1357;
    end
    if (cycles == 30000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic go(input bap_pkg::bap_cfg_t c, input logic tv);
    @(posedge clk);
    cfg <= c;
    tx_valid <= tv;
    run <= 1'b1;
    enable <= 1'b1;
  endtask : go

  // Park the port and drain anything still in flight.
  task automatic stop;
    @(posedge clk);
    enable <= 1'b0;
    run <= 1'b0;
    tx_valid <= 1'b0;
    rx_ready <= 1'b1;
    repeat (100) @(posedge clk);
    sent.delete();
  endtask : stop

  // The far end echoes, so each received word is a sent one, cut to size.
  task automatic take(input logic [4:0] s, input logic [4:0] nb);
    int i;
    logic [15:0] m;
    i = 0;
    m = 16'((17'h0_0001 << nb) - 17'h0_0001);
    do
    begin
      @(posedge clk);
      #1;
      i++;
    end
    while (rx_valid !== 1'b1 && i < 4000);
    check("rx data", sent.pop_front() & m, rx_data.data);
    check("rx slot", 16'(s), 16'(rx_data.slot));
  endtask : take

  task automatic t_master;
    go({1'b1, 9'h100, 6'h02, 5'h08, 9'h014}, 1'b1);
    repeat (3) @(posedge clk);
    #1;
    check("clock drive", 16'h0001, 16'(bclk_oe & fsync_oe));
    for (int k = 0; k < 4; k++)
      take(5'(k % 2), 5'h08);
    stop();
  endtask : t_master

  task automatic t_slave;
    go({1'b0, 9'h008, 6'h01, 5'h10, 9'h014}, 1'b1);
    repeat (3) @(posedge clk);
    #1;
    check("clock drive", 16'h0000, 16'(bclk_oe | fsync_oe));
    take(5'h00, 5'h10);
    take(5'h00, 5'h10);
    stop();
  endtask : t_slave

  // Thirty-two one-bit slots overflow an unread buffer within a frame.
  task automatic t_overrun;
    int n;
    n = 0;
    rx_ready <= 1'b0;
    go({1'b1, 9'h100, 6'h20, 5'h01, 9'h028}, 1'b1);
    while (rx_overrun !== 1'b1 && n < 4000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check("overrun", 16'h0001, 16'(rx_overrun));
    @(posedge clk);
    enable <= 1'b0;
    rx_ready <= 1'b1;
    n = 0;
    repeat (40)
    begin
      #1;
      n += int'(rx_valid === 1'b1);
      @(posedge clk);
    end
    check("words held", 16'h0011, 16'(n));
    stop();
  endtask : t_overrun

  // A fractional divider may stretch one half period by a cycle.
  task automatic t_rate(input logic [8:0] n);
    int t0;
    int lo;
    lo = 32'h0000_30D4 / int'(n);
    go({1'b1, n, 6'h01, 5'h04, 9'h008}, 1'b0);
    @(posedge bclk_o);
    t0 = cycles;
    @(posedge bclk_o);
    t0 = cycles - t0;
    check("clock period", 16'(lo), 16'(t0 > lo ? t0 - 1 : t0));
    stop();
  endtask : t_rate

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop

  // Reset, then each scenario in turn.
  initial
  begin
    reset_n = 1'b0;
    enable = 1'b0;
    run = 1'b0;
    cfg = '0;
    tx_valid = 1'b0;
    tx_data = 16'hC3A5;
    rx_ready = 1'b1;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    t_master();
    t_slave();
    t_overrun();
    t_rate(9'h008);
    t_rate(9'h100);
    report_and_stop();
  end

endmodule : bap_port_test
`default_nettype wire
